// [common/cjb_pkg.sv]
package cjb_pkg;
  localparam logic [5:0] OP_RTYPE = 6'h3a;
  localparam logic [5:0] OP_INITD = 6'h33;
  localparam logic [5:0] OP_JMPI = 6'h01;
  localparam logic [5:0] OP_LDB = 6'h07;
  localparam logic [5:0] OP_LDBIO = 6'h27;
  localparam logic [5:0] OP_LDBU = 6'h03;
  localparam logic [5:0] OP_LDBUIO = 6'h23;
  localparam logic [5:0] XOP_FLUSHP = 6'h04;
  localparam logic [5:0] XOP_FLUSHI = 6'h0c;
  localparam logic [5:0] XOP_INITI = 6'h29;
  localparam logic [5:0] XOP_JMP = 6'h0d;
  localparam int OP_LSB = 0;
  localparam int XOP_LSB = 11;
  localparam int OFFSET_FIELD_LSB = 6;
  localparam int JUMP_FIELD_LSB = 6;
  localparam int REGB_LSB = 22;
  localparam int REGA_LSB = 27;
  localparam int LINE_IDX_LSB = 5;
  localparam int LINE_IDX_W = 6;
  localparam int NUM_LINES = 64;
  localparam logic [4:0] LINK_REG = 5'h1f;
  localparam logic [31:0] RESET_PC = 32'h0000_0000;
  typedef enum logic [1:0] {
    CJB_IDLE,
    CJB_CACHE_RD,
    CJB_BUS_WAIT
  } cjb_state_t;
endpackage

// [hdl/cjb_valid_mem.sv]
`timescale 1ns/1ps
// Per-line valid bits; read data registered
module cjb_valid_mem (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic clr_i,
  input wire logic [cjb_pkg::LINE_IDX_W-1:0] clr_idx_i,
  input wire logic set_i,
  input wire logic [cjb_pkg::LINE_IDX_W-1:0] set_idx_i,
  input wire logic [cjb_pkg::LINE_IDX_W-1:0] rd_idx_i,
  output logic rd_valid_o
);
  typedef struct packed {
    logic [cjb_pkg::NUM_LINES-1:0] valid;
    logic rd_valid;
  } cjb_vm_t;
  cjb_vm_t st;
  cjb_vm_t next_st;
  always_comb begin
    next_st = st;
    if (clr_i) begin
      next_st.valid[clr_idx_i] = 1'b0;
    end
    // Fill after clear: a refill landing with an invalidate keeps the line
    if (set_i) begin
      next_st.valid[set_idx_i] = 1'b1;
    end
    // Read the updated bits so a same-edge change is never missed
    next_st.rd_valid = next_st.valid[rd_idx_i];
  end
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end
  assign rd_valid_o = st.rd_valid;
endmodule

// [hdl/cjb_exec.sv]
`timescale 1ns/1ps
// Contract
// - Prefetch-discard instruction flushes every younger fetched instruction.
// - Effective address is first source register plus sign-extended sixteen-bit offset.
// - Data-cache invalidate clears indexed line valid, no tag compare, no writeback; a fill to that line in the same cycle leaves it valid here.
// - Without data cache, data-cache invalidate does nothing.
// - Instruction-cache invalidate indexes line by first source register, ignores tag.
// - Without instruction cache, instruction-cache invalidate does nothing.
// - Register-indirect jump loads program counter from first source register.
// - Region jump target is pc[31:28] then jump target field times four.
// - Signed byte load sign-extends bit 7 across all 32 bits.
// - Unsigned byte load zero-fills upper 24 bits.
// - Cached byte loads may be answered from the data cache.
// - With data cache, peripheral byte loads always issue a bus read.
// - Without data cache, peripheral byte loads act like ordinary ones.
// - Instruction-cache line flush ignores tag, invalidates line; no-op without cache.
module cjb_exec #(
  parameter bit HAS_DCACHE = 1'b1,
  parameter bit HAS_ICACHE = 1'b1
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic insn_valid_i,
  input wire logic [31:0] insn_i,
  input wire logic [31:0] pc_i,
  input wire logic [31:0] first_source_register_i,
  output logic busy_o,
  output logic pipe_flush_o,
  output logic pc_load_o,
  output logic [31:0] pc_target_o,
  output logic dc_inv_o,
  output logic [cjb_pkg::LINE_IDX_W-1:0] dc_inv_idx_o,
  output logic ic_inv_o,
  output logic [cjb_pkg::LINE_IDX_W-1:0] ic_inv_idx_o,
  output logic bus_read_o,
  output logic [31:0] bus_addr_o,
  input wire logic bus_waitrequest_i,
  input wire logic bus_readdatavalid_i,
  input wire logic [31:0] bus_readdata_i,
  input wire logic dc_fill_i,
  input wire logic [31:0] dc_fill_addr_i,
  input wire logic [7:0] dc_byte_i,
  output logic rf_we_o,
  output logic [4:0] load_destination_register_o,
  output logic [31:0] rf_wdata_o
);
  typedef struct packed {
    cjb_pkg::cjb_state_t fsm;
    logic busy;
    logic pipe_flush;
    logic pc_load;
    logic [31:0] pc_target;
    logic dc_inv;
    logic [cjb_pkg::LINE_IDX_W-1:0] dc_inv_idx;
    logic ic_inv;
    logic [cjb_pkg::LINE_IDX_W-1:0] ic_inv_idx;
    logic bus_read;
    logic [31:0] bus_addr;
    logic is_signed;
    logic [1:0] lane;
    logic rf_we;
    logic [4:0] dst;
    logic [31:0] rf_wdata;
  } cjb_ex_t;
  cjb_ex_t st;
  cjb_ex_t next_st;
  logic [5:0] op;
  logic [5:0] xop;
  logic [31:0] ea;
  logic is_rtype;
  logic hit_valid;
  logic [7:0] bus_byte;
  assign op = insn_i[cjb_pkg::OP_LSB +: 6];
  assign xop = insn_i[cjb_pkg::XOP_LSB +: 6];
  assign is_rtype = (op == cjb_pkg::OP_RTYPE);
  // Sign-extend offset, add to base
  assign ea = first_source_register_i
    + {{16{insn_i[cjb_pkg::OFFSET_FIELD_LSB+15]}},
    insn_i[cjb_pkg::OFFSET_FIELD_LSB +: 16]};
  assign bus_byte = bus_readdata_i[{st.lane, 3'b000} +: 8];
  cjb_valid_mem u_valid (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .clr_i(st.dc_inv),
    .clr_idx_i(st.dc_inv_idx),
    .set_i(dc_fill_i),
    .set_idx_i(dc_fill_addr_i[cjb_pkg::LINE_IDX_LSB +: cjb_pkg::LINE_IDX_W]),
    // Index by the next address so the registered valid belongs to the load just taken
    .rd_idx_i(next_st.bus_addr[cjb_pkg::LINE_IDX_LSB +: cjb_pkg::LINE_IDX_W]),
    .rd_valid_o(hit_valid)
  );
  function automatic logic [31:0] ext_byte(input logic [7:0] b, input logic sgn);
    ext_byte = sgn ? {{24{b[7]}}, b} : {24'h000000, b};
  endfunction
  always_comb begin
    next_st = st;
    next_st.pipe_flush = 1'b0;
    next_st.pc_load = 1'b0;
    next_st.dc_inv = 1'b0;
    next_st.ic_inv = 1'b0;
    next_st.rf_we = 1'b0;
    case (st.fsm)
      cjb_pkg::CJB_IDLE: begin
        if (insn_valid_i) begin
          if (is_rtype && xop == cjb_pkg::XOP_FLUSHP) begin
            next_st.pipe_flush = 1'b1;
          end else if (is_rtype && xop == cjb_pkg::XOP_JMP) begin
            next_st.pc_load = 1'b1;
            next_st.pipe_flush = 1'b1;
            next_st.pc_target = first_source_register_i;
          end else if (is_rtype && (xop == cjb_pkg::XOP_INITI || xop == cjb_pkg::XOP_FLUSHI)) begin
            next_st.ic_inv = HAS_ICACHE;
            next_st.ic_inv_idx =
              first_source_register_i[cjb_pkg::LINE_IDX_LSB +: cjb_pkg::LINE_IDX_W];
          end else if (op == cjb_pkg::OP_INITD) begin
            // Tag ignored, no writeback path at all
            next_st.dc_inv = HAS_DCACHE;
            next_st.dc_inv_idx = ea[cjb_pkg::LINE_IDX_LSB +: cjb_pkg::LINE_IDX_W];
          end else if (op == cjb_pkg::OP_JMPI) begin
            next_st.pc_load = 1'b1;
            next_st.pipe_flush = 1'b1;
            next_st.pc_target =
              {pc_i[31:28], insn_i[cjb_pkg::JUMP_FIELD_LSB +: 26], 2'b00};
          end else if (op == cjb_pkg::OP_LDB || op == cjb_pkg::OP_LDBU
                       || op == cjb_pkg::OP_LDBIO || op == cjb_pkg::OP_LDBUIO) begin
            next_st.busy = 1'b1;
            next_st.bus_addr = ea;
            next_st.lane = ea[1:0];
            next_st.is_signed = (op == cjb_pkg::OP_LDB || op == cjb_pkg::OP_LDBIO);
            next_st.dst = insn_i[cjb_pkg::REGB_LSB +: 5];
            if (HAS_DCACHE && (op == cjb_pkg::OP_LDB || op == cjb_pkg::OP_LDBU)) begin
              next_st.fsm = cjb_pkg::CJB_CACHE_RD;
            end else begin
              // Peripheral form never looks at the cache
              next_st.bus_read = 1'b1;
              next_st.fsm = cjb_pkg::CJB_BUS_WAIT;
            end
          end
        end
      end
      cjb_pkg::CJB_CACHE_RD: begin
        if (hit_valid) begin
          next_st.rf_we = 1'b1;
          next_st.rf_wdata = ext_byte(dc_byte_i, st.is_signed);
          next_st.busy = 1'b0;
          next_st.fsm = cjb_pkg::CJB_IDLE;
        end else begin
          next_st.bus_read = 1'b1;
          next_st.fsm = cjb_pkg::CJB_BUS_WAIT;
        end
      end
      cjb_pkg::CJB_BUS_WAIT: begin
        if (st.bus_read && !bus_waitrequest_i) begin
          next_st.bus_read = 1'b0;
        end
        if (bus_readdatavalid_i) begin
          next_st.bus_read = 1'b0;
          next_st.rf_we = 1'b1;
          next_st.rf_wdata = ext_byte(bus_byte, st.is_signed);
          next_st.busy = 1'b0;
          next_st.fsm = cjb_pkg::CJB_IDLE;
        end
      end
      default: begin
        next_st.fsm = cjb_pkg::CJB_IDLE;
      end
    endcase
  end
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st <= '0;
      st.fsm <= cjb_pkg::CJB_IDLE;
      st.pc_target <= cjb_pkg::RESET_PC;
    end else if (ce_i) begin
      st <= next_st;
    end
  end
  assign busy_o = st.busy;
  assign pipe_flush_o = st.pipe_flush;
  assign pc_load_o = st.pc_load;
  assign pc_target_o = st.pc_target;
  assign dc_inv_o = st.dc_inv;
  assign dc_inv_idx_o = st.dc_inv_idx;
  assign ic_inv_o = st.ic_inv;
  assign ic_inv_idx_o = st.ic_inv_idx;
  assign bus_read_o = st.bus_read;
  assign bus_addr_o = st.bus_addr;
  assign rf_we_o = st.rf_we;
  assign load_destination_register_o = st.dst;
  assign rf_wdata_o = st.rf_wdata;

  pipe_discard_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && st.fsm == cjb_pkg::CJB_IDLE && insn_valid_i && is_rtype
    && xop == cjb_pkg::XOP_FLUSHP |=> pipe_flush_o && !pc_load_o)
    else $error("flush pipeline not issued");
  jmp_target_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && st.fsm == cjb_pkg::CJB_IDLE && insn_valid_i && is_rtype
    && xop == cjb_pkg::XOP_JMP |=> pc_load_o && pc_target_o == $past(first_source_register_i))
    else $error("indirect jump target wrong");
  jmpi_region_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && st.fsm == cjb_pkg::CJB_IDLE && insn_valid_i && op == cjb_pkg::OP_JMPI
    |=> pc_target_o[31:28] == $past(pc_i[31:28]) && pc_target_o[1:0] == 2'b00
    && pc_target_o[27:2] == $past(insn_i[31:6]))
    else $error("region jump target wrong");
  dc_inv_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && st.fsm == cjb_pkg::CJB_IDLE && insn_valid_i && op == cjb_pkg::OP_INITD
    |=> dc_inv_o == HAS_DCACHE && dc_inv_idx_o == $past(ea[10:5]))
    else $error("data line invalidate wrong");
  ic_inv_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && st.fsm == cjb_pkg::CJB_IDLE && insn_valid_i && is_rtype
    && xop == cjb_pkg::XOP_INITI |=> ic_inv_o == HAS_ICACHE
    && ic_inv_idx_o == $past(first_source_register_i[10:5]))
    else $error("instruction line invalidate wrong");
  io_bypass_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && st.fsm == cjb_pkg::CJB_IDLE && insn_valid_i
    && (op == cjb_pkg::OP_LDBIO || op == cjb_pkg::OP_LDBUIO)
    |=> bus_read_o && bus_addr_o == $past(ea))
    else $error("peripheral load missed bus");
  signed_ext_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    rf_we_o && $past(st.is_signed) |-> rf_wdata_o[31:8] == {24{rf_wdata_o[7]}})
    else $error("sign extension wrong");
  unsigned_ext_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    rf_we_o && !$past(st.is_signed) |-> rf_wdata_o[31:8] == 24'h000000)
    else $error("zero extension wrong");
  load_done_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    st.fsm == cjb_pkg::CJB_CACHE_RD && ce_i && hit_valid |=> rf_we_o && !busy_o)
    else $error("cache hit not returned");
  jmp_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) pc_load_o);
  hit_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    st.fsm == cjb_pkg::CJB_CACHE_RD && hit_valid);
  bus_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    bus_readdatavalid_i && st.fsm == cjb_pkg::CJB_BUS_WAIT);
  inv_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) dc_inv_o || ic_inv_o);
endmodule

// [verif/cjb_tb_pkg.sv]
package cjb_tb_pkg;
  // Address-derived byte pattern so every lane and sign is exercised
  function automatic logic [7:0] mem_byte(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h96;
  endfunction
endpackage

// [verif/cjb_mem_model.sv]
`timescale 1ns/1ps
module cjb_mem_model (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic bus_read_i,
  input wire logic [31:0] bus_addr_i,
  input wire logic [3:0] wait_cycles_i,
  output logic waitrequest_o,
  output logic readdatavalid_o,
  output logic [31:0] readdata_o,
  output int reads_o
);
  logic [3:0] cnt;
  logic [31:0] word;
  logic [31:0] last;
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      word[8*k +: 8] = cjb_tb_pkg::mem_byte({bus_addr_i[31:2], 2'(k)});
    end
  end
  assign waitrequest_o = bus_read_i && (cnt < wait_cycles_i);
  assign readdatavalid_o = bus_read_i && !waitrequest_o;
  // Outside the data cycle the lanes show junk, never the last word
  assign readdata_o = readdatavalid_o ? word : ~last;
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cnt <= 4'h0;
      last <= 32'h0;
      reads_o <= 0;
    end else if (readdatavalid_o) begin
      cnt <= 4'h0;
      last <= word;
      reads_o <= reads_o + 1;
    end else if (bus_read_i) begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

// [verif/test_cache_jump_byte_load_ops.sv]
`timescale 1ns/1ps
module test_cache_jump_byte_load_ops;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic insn_valid_i = 1'b0;
  logic [31:0] insn_i = 32'h0;
  logic [31:0] pc_i = 32'h0;
  logic [31:0] src_a = 32'h0;
  logic dc_fill_i = 1'b0;
  logic [31:0] dc_fill_addr_i = 32'h0;
  logic [3:0] wait_cycles = 4'h0;
  logic busy_o, pipe_flush_o, pc_load_o, dc_inv_o, ic_inv_o, bus_read_o, rf_we_o, wr, dv;
  logic [31:0] pc_target_o, bus_addr_o, rf_wdata_o, rdata, last_rf;
  logic [5:0] dc_inv_idx_o, ic_inv_idx_o, last_dc, last_ic;
  logic [4:0] rd_o, last_rd;
  logic [7:0] dc_byte_i;
  logic [15:0] lfsr = 16'hd567;
  logic line_ok [64];
  logic [5:0] ops [4] = '{cjb_pkg::OP_LDB, cjb_pkg::OP_LDBU, cjb_pkg::OP_LDBIO, cjb_pkg::OP_LDBUIO};
  int bad_count = 0;
  int checks = 0;
  int n_fl = 0;
  int n_pc = 0;
  int n_bus;
  always #20 core_clk_i = ~core_clk_i;
  assign dc_byte_i = cjb_tb_pkg::mem_byte(bus_addr_o);
  cjb_exec cjb_exec_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
    .insn_valid_i(insn_valid_i), .insn_i(insn_i), .pc_i(pc_i), .first_source_register_i(src_a),
    .busy_o(busy_o), .pipe_flush_o(pipe_flush_o), .pc_load_o(pc_load_o),
    .pc_target_o(pc_target_o), .dc_inv_o(dc_inv_o), .dc_inv_idx_o(dc_inv_idx_o),
    .ic_inv_o(ic_inv_o), .ic_inv_idx_o(ic_inv_idx_o), .bus_read_o(bus_read_o),
    .bus_addr_o(bus_addr_o), .bus_waitrequest_i(wr), .bus_readdatavalid_i(dv),
    .bus_readdata_i(rdata), .dc_fill_i(dc_fill_i), .dc_fill_addr_i(dc_fill_addr_i),
    .dc_byte_i(dc_byte_i), .rf_we_o(rf_we_o), .load_destination_register_o(rd_o),
    .rf_wdata_o(rf_wdata_o));
  cjb_mem_model cjb_mem_model_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .bus_read_i(bus_read_o), .bus_addr_i(bus_addr_o), .wait_cycles_i(wait_cycles),
    .waitrequest_o(wr), .readdatavalid_o(dv), .readdata_o(rdata), .reads_o(n_bus));
  always @(negedge core_clk_i) begin
    n_fl += int'(pipe_flush_o === 1'b1);
    n_pc += int'(pc_load_o === 1'b1);
    last_dc = (dc_inv_o === 1'b1) ? dc_inv_idx_o : last_dc;
    last_ic = (ic_inv_o === 1'b1) ? ic_inv_idx_o : last_ic;
    last_rf = (rf_we_o === 1'b1) ? rf_wdata_o : last_rf;
    last_rd = (rf_we_o === 1'b1) ? rd_o : last_rd;
  end
  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic rnd(output logic [31:0] r);
    repeat (2) begin
      lfsr = step(lfsr);
      r = {r[15:0], lfsr};
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic issue(input logic [31:0] w, input logic [31:0] pc, input logic [31:0] a);
    @(posedge core_clk_i);
    insn_valid_i <= 1'b1;
    insn_i <= w;
    pc_i <= pc;
    src_a <= a;
    @(posedge core_clk_i);
    insn_valid_i <= 1'b0;
    @(negedge core_clk_i);
    for (int i = 0; i < 40 && busy_o !== 1'b0; i++) @(negedge core_clk_i);
    repeat (3) @(negedge core_clk_i);
  endtask
  task automatic rtype(input logic [5:0] xop, input logic [31:0] a);
    issue({5'h05, 10'h0, xop, 5'h0, cjb_pkg::OP_RTYPE}, 32'h0, a);
  endtask
  task automatic initd(input logic [31:0] a, input logic [15:0] imm);
    logic [31:0] ea;
    ea = a + {{16{imm[15]}}, imm};
    issue({5'h06, 5'h0, imm, cjb_pkg::OP_INITD}, 32'h0, a);
    chk(32'(last_dc), 32'(ea[10:5]));
    line_ok[ea[10:5]] = 1'b0;
  endtask
  task automatic load(input logic [5:0] op, input logic [31:0] a, input logic [15:0] imm,
                      input logic [4:0] rd);
    logic [31:0] ea;
    logic [7:0] b;
    int nb;
    logic io;
    logic [31:0] want;
    ea = a + {{16{imm[15]}}, imm};
    b = cjb_tb_pkg::mem_byte(ea);
    nb = n_bus;
    io = (op == cjb_pkg::OP_LDBIO) || (op == cjb_pkg::OP_LDBUIO);
    issue({5'h06, rd, imm, op}, 32'h0, a);
    want = (op == cjb_pkg::OP_LDB || op == cjb_pkg::OP_LDBIO) ? {{24{b[7]}}, b} : {24'h0, b};
    chk(last_rf, want);
    chk(32'(last_rd), 32'(rd));
    chk(32'(n_bus - nb), (io || !line_ok[ea[10:5]]) ? 32'h1 : 32'h0);
    if (!io) begin
      @(posedge core_clk_i);
      dc_fill_i <= 1'b1;
      dc_fill_addr_i <= ea;
      @(posedge core_clk_i);
      dc_fill_i <= 1'b0;
      line_ok[ea[10:5]] = 1'b1;
    end
  endtask
  initial begin
    #400000;
    bad_count++;
    give_verdict;
  end
  initial begin
    logic [31:0] a;
    logic [31:0] p;
    int f;
    int q;
    repeat (12) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 64; i++) begin
      initd(32'(i) << 5, 16'h0);
      rtype(cjb_pkg::XOP_INITI, 32'(i) << 5);
      chk(32'(last_ic), 32'(i));
    end
    rnd(a);
    rtype(cjb_pkg::XOP_FLUSHI, a);
    chk(32'(last_ic), 32'(a[10:5]));
    rnd(a);
    initd(a, a[31:16] | 16'h8000);
    f = n_fl;
    q = n_pc;
    rtype(cjb_pkg::XOP_FLUSHP, 32'h0);
    chk(32'(n_fl - f), 32'h1);
    chk(32'(n_pc - q), 32'h0);
    rnd(a);
    rtype(cjb_pkg::XOP_JMP, a);
    chk(last_pc_val(), a);
    rnd(a);
    rnd(p);
    issue({a[25:0], cjb_pkg::OP_JMPI}, p, 32'h0);
    chk(last_pc_val(), {p[31:28], a[25:0], 2'b00});
    chk(32'(n_pc - q), 32'h2);
    chk(32'(n_fl - f), 32'h3);
    for (int k = 0; k < 12; k++) begin
      rnd(a);
      rnd(p);
      wait_cycles <= p[3:0] & 4'h3;
      // Cached ops: miss, then hit after fill, then miss again after invalidation; peripheral ops read the bus all three times
      load(ops[k % 4], a, p[31:16], p[8:4]);
      load(ops[k % 4], a, p[31:16], p[8:4]);
      initd(a, p[31:16]);
      load(ops[k % 4], a, p[31:16], p[8:4]);
    end
    give_verdict;
  end
  function automatic logic [31:0] last_pc_val();
    return pc_target_o;
  endfunction
endmodule
